// ---- pkg/table_protect_pkg.sv ----
// Address map, field layout and reset values of the table access protection block
package table_protect_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 8;
    localparam int BLOCK_COUNT = 4;
    localparam int BLOCK_SHIFT = 13;
    // Program memory regions
    localparam logic [21:0] BOOT_LIMIT = 22'h000800;
    localparam logic [21:0] USER_LIMIT = 22'h008000;
    // Configuration and identification space
    localparam logic [21:0] CFG_CP_LOW_ADDR = 22'h300008;
    localparam logic [21:0] CFG_CP_HIGH_ADDR = 22'h300009;
    localparam logic [21:0] CFG_WP_LOW_ADDR = 22'h30000a;
    localparam logic [21:0] CFG_WP_HIGH_ADDR = 22'h30000b;
    localparam logic [21:0] CFG_RP_LOW_ADDR = 22'h30000c;
    localparam logic [21:0] CFG_RP_HIGH_ADDR = 22'h30000d;
    localparam logic [21:0] DEVID_LOW_ADDR = 22'h3ffffe;
    localparam logic [21:0] DEVID_HIGH_ADDR = 22'h3fffff;
    // Field positions
    localparam int DATA_PROT_BIT = 7;
    localparam int BOOT_PROT_BIT = 6;
    localparam int BLOCK_LSB = 0;
    // Unprogrammed values: all ones means no protection
    localparam logic PROT_RESET = 1'b1;
    localparam logic [3:0] BLOCK_PROT_RESET = 4'hf;
    // Identification word, value arbitrary
    localparam logic [15:0] DEVICE_ID_DEFAULT = 16'h5a30;
endpackage

// ---- sim/table_memory_model.sv ----
// Behavioural program and data memory on the far side of the protection gate
`timescale 1ns/1ps
module table_memory_model
    import table_protect_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_mem_rd,
    input wire logic [ADDR_W-1:0] i_mem_addr,
    output logic [DATA_W-1:0] o_rdata
);
    // ************************************************************
    // Read port
    // ************************************************************
    // Data is valid only in the cycle after a strobe; otherwise it toggles
    // so a design that samples at the wrong moment sees garbage.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_mem_rd) begin
            o_rdata <= i_mem_addr[7:0] ^ 8'h3c;
        end else begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule // table_memory_model

// ---- sim/testbench.sv ----
// Self-checking bench for the table access protection gate
`timescale 1ns/1ps
module testbench;
    import table_protect_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_prog_mode = 1'b0;
    logic i_tbl_rd = 1'b0;
    logic i_tbl_wr = 1'b0;
    logic [ADDR_W-1:0] i_table_pointer = 22'h000000;
    logic [ADDR_W-1:0] i_exec_addr = 22'h000000;
    logic [DATA_W-1:0] i_tbl_wdata = 8'h00;
    logic i_prog_rd = 1'b0;
    logic i_prog_wr = 1'b0;
    logic i_prog_eeprom = 1'b0;
    logic [ADDR_W-1:0] i_prog_addr = 22'h000000;
    logic [DATA_W-1:0] i_prog_wdata = 8'h00;
    logic i_prog_chip_erase = 1'b0;
    logic i_prog_block_erase = 1'b0;
    logic [DATA_W-1:0] i_mem_rdata;
    logic o_mem_rd, o_mem_wr, o_mem_eeprom, o_rd_done, o_rd_blocked, o_wr_blocked;
    logic [ADDR_W-1:0] o_mem_addr;
    logic [DATA_W-1:0] o_mem_wdata, o_rd_data, o_code_protect_config_high;
    logic [DATA_W-1:0] o_write_protect_config_low;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;

    always #2.5 i_clk = ~i_clk;

    table_access_code_protect dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_prog_mode(i_prog_mode), .i_tbl_rd(i_tbl_rd), .i_tbl_wr(i_tbl_wr),
        .i_table_pointer(i_table_pointer), .i_exec_addr(i_exec_addr),
        .i_tbl_wdata(i_tbl_wdata), .i_prog_rd(i_prog_rd), .i_prog_wr(i_prog_wr),
        .i_prog_eeprom(i_prog_eeprom), .i_prog_addr(i_prog_addr),
        .i_prog_wdata(i_prog_wdata), .i_prog_chip_erase(i_prog_chip_erase),
        .i_prog_block_erase(i_prog_block_erase), .i_mem_rdata(i_mem_rdata),
        .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_eeprom(o_mem_eeprom),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_rd_data(o_rd_data),
        .o_rd_done(o_rd_done), .o_rd_blocked(o_rd_blocked), .o_wr_blocked(o_wr_blocked),
        .o_code_protect_config_high(o_code_protect_config_high),
        .o_write_protect_config_low(o_write_protect_config_low));

    table_memory_model mem (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mem_rd(o_mem_rd),
        .i_mem_addr(o_mem_addr), .o_rdata(i_mem_rdata));

    // ************************************************************
    // Comparison and verdict
    // ************************************************************
    task automatic chk(input logic [21:0] got, input logic [21:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Whole run is about a hundred cycles; this ceiling only catches a hang
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errors++;
            print_verdict();
        end
    end

    function automatic logic [7:0] pat(input logic [21:0] a);
        return a[7:0] ^ 8'h3c;
    endfunction

    // ************************************************************
    // Access tasks
    // ************************************************************
    task automatic access(input bit prog, input bit wr, input bit ee, input logic [21:0] a,
            input logic [21:0] ex, input logic [7:0] wd, input logic [7:0] exp_d,
            input bit blk);
        @(posedge i_clk);
        i_prog_eeprom <= ee;
        i_prog_addr <= a;
        i_table_pointer <= a;
        i_exec_addr <= ex;
        i_tbl_wdata <= wd;
        i_prog_wdata <= wd;
        if (prog) begin
            i_prog_rd <= !wr;
            i_prog_wr <= wr;
        end else begin
            i_tbl_rd <= !wr;
            i_tbl_wr <= wr;
        end
        @(posedge i_clk);
        i_prog_rd <= 1'b0;
        i_prog_wr <= 1'b0;
        i_tbl_rd <= 1'b0;
        i_tbl_wr <= 1'b0;
        #1;
        chk(o_mem_addr, a, "address");
        if (wr) begin
            chk(o_mem_wr, !blk && a < 22'h300000, "write strobe");
            chk(o_wr_blocked, blk, "write blocked");
            if (!blk && a < 22'h300000) chk(o_mem_wdata, wd, "write data");
        end else begin
            chk(o_mem_rd, !blk && a < 22'h300000, "read strobe");
            if (!blk && a < 22'h300000) chk(o_mem_eeprom, ee, "eeprom select");
            @(posedge i_clk);
            @(posedge i_clk);
            #1;
            chk(o_rd_done, 1'b1, "read done");
            chk(o_rd_blocked, blk, "read blocked");
            chk(o_rd_data, exp_d, "read data");
        end
    endtask

    task automatic erase(input bit chip, input logic [21:0] a);
        @(posedge i_clk);
        i_prog_chip_erase <= chip;
        i_prog_block_erase <= !chip;
        i_prog_addr <= a;
        @(posedge i_clk);
        i_prog_chip_erase <= 1'b0;
        i_prog_block_erase <= 1'b0;
        #1;
    endtask

    task automatic cfg(input logic [7:0] hi, input logic [7:0] lo);
        chk(o_code_protect_config_high, hi, "config high");
        chk(o_write_protect_config_low, lo, "config low");
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1;
        cfg(8'hc0, 8'h0f);
        $display("test reset done");
        access(0, 1'b0, 0, 22'h000123, 22'h000000, 8'h00, pat(22'h000123), 0);
        access(0, 1'b1, 0, 22'h007f00, 22'h000000, 8'ha5, 8'h00, 0);
        access(0, 1'b0, 0, CFG_CP_HIGH_ADDR, 22'h000000, 8'h00, 8'hc0, 0);
        $display("test open access done");
        access(0, 1'b1, 0, CFG_WP_LOW_ADDR, 22'h000000, 8'hfa, 8'h00, 0);
        cfg(8'hc0, 8'h0a);
        access(0, 1'b1, 0, CFG_WP_LOW_ADDR, 22'h000000, 8'hff, 8'h00, 0);
        cfg(8'hc0, 8'h0a);
        access(0, 1'b0, 0, CFG_WP_LOW_ADDR, 22'h000000, 8'h00, 8'h0a, 0);
        for (int n = 0; n < 4; n++) begin
            access(0, 1'b1, 0, {7'h00, n[1:0], 13'h1100}, 22'h000000, 8'h5a, 8'h00,
                   n == 0 || n == 2);
        end
        access(0, 1'b1, 0, 22'h000100, 22'h000000, 8'h33, 8'h00, 0);
        $display("test write protect done");
        access(0, 1'b1, 0, CFG_RP_LOW_ADDR, 22'h000000, 8'hfd, 8'h00, 0);
        access(0, 1'b0, 0, 22'h002200, 22'h002010, 8'h00, pat(22'h002200), 0);
        access(0, 1'b0, 0, 22'h002200, 22'h000900, 8'h00, 8'h00, 1);
        access(0, 1'b0, 0, 22'h004200, 22'h000900, 8'h00, pat(22'h004200), 0);
        $display("test read protect done");
        access(0, 1'b1, 0, CFG_CP_HIGH_ADDR, 22'h000000, 8'h3f, 8'h00, 0);
        cfg(8'h00, 8'h0a);
        access(0, 1'b0, 0, 22'h000100, 22'h004000, 8'h00, pat(22'h000100), 0);
        access(0, 1'b1, 0, CFG_CP_LOW_ADDR, 22'h000000, 8'hfb, 8'h00, 0);
        access(0, 1'b0, 0, CFG_CP_LOW_ADDR, 22'h000000, 8'h00, 8'h0b, 0);
        access(0, 1'b0, 0, 22'h005200, 22'h000000, 8'h00, pat(22'h005200), 0);
        erase(1, 22'h000000);
        cfg(8'h00, 8'h0a);
        $display("test code protect done");
        @(posedge i_clk);
        i_prog_mode <= 1'b1;
        access(1, 1'b0, 1, 22'h000010, 22'h000000, 8'h00, 8'h00, 1);
        access(1, 1'b0, 0, 22'h000100, 22'h000000, 8'h00, 8'h00, 1);
        access(1, 1'b1, 0, 22'h000100, 22'h000000, 8'h77, 8'h00, 1);
        access(1, 1'b0, 0, 22'h005200, 22'h000000, 8'h00, 8'h00, 1);
        access(1, 1'b0, 0, 22'h002200, 22'h000000, 8'h00, pat(22'h002200), 0);
        erase(0, 22'h000100);
        cfg(8'h40, 8'h0a);
        erase(0, 22'h001100);
        cfg(8'h40, 8'h0b);
        access(1, 1'b0, 1, 22'h000010, 22'h000000, 8'h00, 8'h00, 1);
        erase(1, 22'h000000);
        cfg(8'hc0, 8'h0f);
        access(1, 1'b0, 1, 22'h000010, 22'h000000, 8'h00, pat(22'h000010), 0);
        $display("test programmer done");
        @(posedge i_clk);
        i_prog_mode <= 1'b0;
        access(0, 1'b0, 0, DEVID_LOW_ADDR, 22'h000000, 8'h00, DEVICE_ID_DEFAULT[7:0], 0);
        access(0, 1'b0, 0, DEVID_HIGH_ADDR, 22'h000000, 8'h00, DEVICE_ID_DEFAULT[15:8], 0);
        $display("test identification done");
        print_verdict();
    end
endmodule // testbench

// ---- src/region_decode.sv ----
// Splits a program memory address into boot region or user block index
`timescale 1ns/1ps
module region_decode
    import table_protect_pkg::*;
(
    input wire logic [ADDR_W-1:0] i_addr,
    output logic o_is_boot,
    output logic o_is_user,
    output logic [1:0] o_block_index
);
    always_comb begin
        o_is_boot = (i_addr < BOOT_LIMIT);
        o_is_user = (i_addr >= BOOT_LIMIT) && (i_addr < USER_LIMIT);
        o_block_index = i_addr[BLOCK_SHIFT+1:BLOCK_SHIFT];
    end
endmodule // region_decode

// ---- src/table_access_code_protect.sv ----
// Protection gate between table accesses, the external programmer and memory
//Function
//- Upper byte bit 7 set leaves data EEPROM open, clear protects it externally.
//- Upper byte bit 6 set leaves boot region open, clear code-protects it.
//- Unused bits of both protection bytes read as zero.
//- Block write-protect bit clear suppresses every table write into that block.
//- All protection bits are one when unprogrammed; software can only clear them.
//- Code-protect bits restrict only the external programmer, never normal execution.
//- Read-protected block still readable by table reads executing inside it.
//- Table reads from outside a read-protected block return zeros.
//- Writes move protection bits only from one to zero, never back.
//- Only system reset or programmer chip or block erase returns protection bits to one.
//- Unprotected, table reads and writes reach every program memory location.
//- Configuration bytes readable and writable by table ops; identification word readable.
`timescale 1ns/1ps
module table_access_code_protect
    import table_protect_pkg::*;
#(
    parameter logic [15:0] DEVICE_ID = DEVICE_ID_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_prog_mode,
    input wire logic i_tbl_rd,
    input wire logic i_tbl_wr,
    input wire logic [ADDR_W-1:0] i_table_pointer,
    input wire logic [ADDR_W-1:0] i_exec_addr,
    input wire logic [DATA_W-1:0] i_tbl_wdata,
    input wire logic i_prog_rd,
    input wire logic i_prog_wr,
    input wire logic i_prog_eeprom,
    input wire logic [ADDR_W-1:0] i_prog_addr,
    input wire logic [DATA_W-1:0] i_prog_wdata,
    input wire logic i_prog_chip_erase,
    input wire logic i_prog_block_erase,
    input wire logic [DATA_W-1:0] i_mem_rdata,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic o_mem_eeprom,
    output logic [ADDR_W-1:0] o_mem_addr,
    output logic [DATA_W-1:0] o_mem_wdata,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_rd_done,
    output logic o_rd_blocked,
    output logic o_wr_blocked,
    output logic [DATA_W-1:0] o_code_protect_config_high,
    output logic [DATA_W-1:0] o_write_protect_config_low
);
    // ************************************************************
    // Protection bits
    // ************************************************************
    logic data_mem_protect;
    logic boot_region_protect;
    logic boot_write_protect;
    logic boot_read_protect;
    logic [BLOCK_COUNT-1:0] block_code_protect;
    logic [BLOCK_COUNT-1:0] block_write_protect;
    logic [BLOCK_COUNT-1:0] block_read_protect;

    // ************************************************************
    // Request selection and decode
    // ************************************************************
    logic src_rd, src_wr, src_ee;
    logic [ADDR_W-1:0] src_addr;
    logic [DATA_W-1:0] src_wdata;
    logic ptr_boot, ptr_user, exec_boot, exec_user;
    logic [1:0] ptr_idx, exec_idx;
    logic cfg_hit, id_hit, mem_hit, same_region;
    logic rd_prot, wr_prot, cp_prot, rd_block, wr_block;
    logic [DATA_W-1:0] cfg_value;

    // Programmer owns the port while in programming mode
    assign src_rd = i_prog_mode ? i_prog_rd : i_tbl_rd;
    assign src_wr = i_prog_mode ? i_prog_wr : i_tbl_wr;
    assign src_ee = i_prog_mode & i_prog_eeprom;
    assign src_addr = i_prog_mode ? i_prog_addr : i_table_pointer;
    assign src_wdata = i_prog_mode ? i_prog_wdata : i_tbl_wdata;

    region_decode u_ptr_decode (
        .i_addr(src_addr),
        .o_is_boot(ptr_boot),
        .o_is_user(ptr_user),
        .o_block_index(ptr_idx)
    );

    region_decode u_exec_decode (
        .i_addr(i_exec_addr),
        .o_is_boot(exec_boot),
        .o_is_user(exec_user),
        .o_block_index(exec_idx)
    );

    always_comb begin
        cfg_hit = !src_ee && (src_addr >= CFG_CP_LOW_ADDR) && (src_addr <= CFG_RP_HIGH_ADDR);
        id_hit = !src_ee && (src_addr >= DEVID_LOW_ADDR);
        mem_hit = src_ee || (!cfg_hit && !id_hit);
        same_region = (ptr_boot && exec_boot) || (ptr_user && exec_user && ptr_idx == exec_idx);
        rd_prot = ptr_boot ? !boot_read_protect : ptr_user && !block_read_protect[ptr_idx];
        wr_prot = ptr_boot ? !boot_write_protect : ptr_user && !block_write_protect[ptr_idx];
        cp_prot = src_ee ? !data_mem_protect :
            ptr_boot ? !boot_region_protect :
            ptr_user && !block_code_protect[ptr_idx];
        // Core side: read-protect honours the executing block, CP ignored
        if (i_prog_mode) begin
            rd_block = mem_hit && cp_prot;
            wr_block = mem_hit && cp_prot;
        end else begin
            rd_block = mem_hit && rd_prot && !same_region;
            wr_block = mem_hit && wr_prot;
        end
        case (src_addr)
            CFG_CP_LOW_ADDR: cfg_value = {4'h0, block_code_protect};
            CFG_CP_HIGH_ADDR: cfg_value = o_code_protect_config_high;
            CFG_WP_LOW_ADDR: cfg_value = o_write_protect_config_low;
            CFG_WP_HIGH_ADDR: cfg_value = {1'b0, boot_write_protect, 6'h00};
            CFG_RP_LOW_ADDR: cfg_value = {4'h0, block_read_protect};
            CFG_RP_HIGH_ADDR: cfg_value = {1'b0, boot_read_protect, 6'h00};
            DEVID_LOW_ADDR: cfg_value = DEVICE_ID[7:0];
            DEVID_HIGH_ADDR: cfg_value = DEVICE_ID[15:8];
            default: cfg_value = 8'h00;
        endcase
    end

    // Unused positions are never stored, so they read back as zero
    assign o_code_protect_config_high = {data_mem_protect, boot_region_protect, 6'h00};
    assign o_write_protect_config_low = {4'h0, block_write_protect};

    // ************************************************************
    // Configuration update: clear by write, set only by erase or reset
    // ************************************************************
    logic cfg_wr, blk_erase_boot;
    logic [BLOCK_COUNT-1:0] blk_erase_sel;
    assign cfg_wr = src_wr && cfg_hit;
    assign blk_erase_boot = i_prog_mode && i_prog_block_erase && ptr_boot;

    genvar g;
    generate
        for (g = 0; g < BLOCK_COUNT; g++) begin : g_block
            assign blk_erase_sel[g] = i_prog_mode && i_prog_block_erase && ptr_user
                && ptr_idx == 2'(g);
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    block_code_protect[g] <= BLOCK_PROT_RESET[g];
                    block_write_protect[g] <= BLOCK_PROT_RESET[g];
                    block_read_protect[g] <= BLOCK_PROT_RESET[g];
                end else if ((i_prog_mode && i_prog_chip_erase) || blk_erase_sel[g]) begin
                    block_code_protect[g] <= 1'b1;
                    block_write_protect[g] <= 1'b1;
                    block_read_protect[g] <= 1'b1;
                end else if (cfg_wr) begin
                    // AND with the written value: a one never sets a cleared bit
                    if (src_addr == CFG_CP_LOW_ADDR)
                        block_code_protect[g] <= block_code_protect[g] & src_wdata[g];
                    if (src_addr == CFG_WP_LOW_ADDR)
                        block_write_protect[g] <= block_write_protect[g] & src_wdata[g];
                    if (src_addr == CFG_RP_LOW_ADDR)
                        block_read_protect[g] <= block_read_protect[g] & src_wdata[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            data_mem_protect <= PROT_RESET;
            boot_region_protect <= PROT_RESET;
            boot_write_protect <= PROT_RESET;
            boot_read_protect <= PROT_RESET;
        end else if (i_prog_mode && i_prog_chip_erase) begin
            data_mem_protect <= 1'b1;
            boot_region_protect <= 1'b1;
            boot_write_protect <= 1'b1;
            boot_read_protect <= 1'b1;
        end else if (blk_erase_boot) begin
            boot_region_protect <= 1'b1;
            boot_write_protect <= 1'b1;
            boot_read_protect <= 1'b1;
        end else if (cfg_wr) begin
            if (src_addr == CFG_CP_HIGH_ADDR) begin
                data_mem_protect <= data_mem_protect & src_wdata[DATA_PROT_BIT];
                boot_region_protect <= boot_region_protect & src_wdata[BOOT_PROT_BIT];
            end
            if (src_addr == CFG_WP_HIGH_ADDR)
                boot_write_protect <= boot_write_protect & src_wdata[BOOT_PROT_BIT];
            if (src_addr == CFG_RP_HIGH_ADDR)
                boot_read_protect <= boot_read_protect & src_wdata[BOOT_PROT_BIT];
        end
    end

    // ************************************************************
    // Memory port, one cycle after the request
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_mem_rd <= 1'b0;
            o_mem_wr <= 1'b0;
            o_wr_blocked <= 1'b0;
        end else begin
            o_mem_rd <= src_rd && mem_hit && !rd_block;
            o_mem_wr <= src_wr && mem_hit && !wr_block;
            o_wr_blocked <= src_wr && mem_hit && wr_block;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_mem_eeprom <= 1'b0;
            o_mem_addr <= '0;
            o_mem_wdata <= '0;
        end else if (src_rd || src_wr) begin
            o_mem_eeprom <= src_ee;
            o_mem_addr <= src_addr;
            o_mem_wdata <= src_wdata;
        end
    end

    // ************************************************************
    // Read return, three cycles after the request
    // ************************************************************
    // Memory is synchronous, so its data lags the strobe by a cycle
    logic [1:0] rd_pend, rd_from_mem, rd_blk;
    logic [DATA_W-1:0] rd_val1, rd_val2;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_pend <= 2'b00;
            rd_from_mem <= 2'b00;
            rd_blk <= 2'b00;
            rd_val1 <= '0;
            rd_val2 <= '0;
        end else begin
            rd_pend <= {rd_pend[0], src_rd};
            rd_from_mem <= {rd_from_mem[0], src_rd && mem_hit && !rd_block};
            rd_blk <= {rd_blk[0], src_rd && rd_block};
            rd_val1 <= (mem_hit || !src_rd) ? 8'h00 : cfg_value;
            rd_val2 <= rd_val1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rd_done <= 1'b0;
            o_rd_blocked <= 1'b0;
            o_rd_data <= '0;
        end else begin
            o_rd_done <= rd_pend[1];
            o_rd_blocked <= rd_blk[1];
            o_rd_data <= rd_from_mem[1] ? i_mem_rdata : rd_val2;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence core_rd_seq;
        !i_prog_mode && i_tbl_rd;
    endsequence

    sequence core_wr_seq;
        !i_prog_mode && i_tbl_wr;
    endsequence

    a_read_latency: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        core_rd_seq |-> ##1 !o_rd_done ##1 !o_rd_done ##1 o_rd_done)
        else $error("read answer not three cycles after request");
    a_blocked_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        core_rd_seq ##0 (ptr_user && !block_read_protect[ptr_idx] && !same_region)
        |-> ##1 !o_mem_rd ##2 (o_rd_blocked && o_rd_data == 8'h00))
        else $error("protected read did not return zeros");
    a_same_block_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        core_rd_seq ##0 (ptr_user && exec_user && ptr_idx == exec_idx)
        |=> o_mem_rd ##2 !o_rd_blocked)
        else $error("read from inside block was refused");
    a_write_suppress: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        core_wr_seq ##0 (ptr_user && !block_write_protect[ptr_idx]) |=> !o_mem_wr && o_wr_blocked)
        else $error("write into protected block reached memory");
    a_normal_ignores_cp: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        core_wr_seq ##0 (ptr_user && block_write_protect[ptr_idx]) |=> o_mem_wr)
        else $error("code-protect bit blocked normal execution");
    a_open_access: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        core_rd_seq ##0 (mem_hit && block_read_protect == 4'hf && boot_read_protect)
        |=> o_mem_rd && o_mem_addr == $past(i_table_pointer))
        else $error("unprotected read did not reach memory");
    a_clear_only: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !(i_prog_mode && (i_prog_chip_erase || i_prog_block_erase))
        |=> (o_write_protect_config_low & ~$past(o_write_protect_config_low)) == 8'h00
            && (o_code_protect_config_high & ~$past(o_code_protect_config_high)) == 8'h00)
        else $error("protection bit set without erase");
    a_unused_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_code_protect_config_high[5:0] == 6'h00 && o_write_protect_config_low[7:4] == 4'h0)
        else $error("unused configuration bit not zero");
    a_reset_open: assert property (@(posedge i_clk)
        i_sys_rst |=> o_code_protect_config_high == 8'hc0
            && o_write_protect_config_low == 8'h0f)
        else $error("protection bits not unprogrammed after reset");
    a_eeprom_guard: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_prog_mode && i_prog_rd && i_prog_eeprom && !data_mem_protect |=> !o_mem_rd)
        else $error("protected data memory read by programmer");
    a_boot_guard: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_prog_mode && i_prog_wr && !i_prog_eeprom && i_prog_addr < BOOT_LIMIT
        && !boot_region_protect |=> !o_mem_wr)
        else $error("protected boot region written by programmer");
    a_erase_restore: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_prog_mode && i_prog_chip_erase |=> o_code_protect_config_high == 8'hc0
            && o_write_protect_config_low == 8'h0f)
        else $error("chip erase did not restore protection bits");
endmodule // table_access_code_protect
